/* design/tmrctl_pkg.sv */
/*
  Shared constants and types for the timer control block: register offsets,
  field positions, reset values, mode and command codes, prescaler masks.
  Assumes an 8-bit register port addressed by byte offset.
*/
package tmrctl_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [5:0] ADDR_CTRL_A = 6'h00; // Enable, prescaler, standby
  localparam logic [5:0] ADDR_CTRL_B = 6'h01; // Output enables, auto-lock, mode
  localparam logic [5:0] ADDR_CTRL_C = 6'h02; // Output value override
  localparam logic [5:0] ADDR_CTRL_D = 6'h03; // Split mode select
  localparam logic [5:0] ADDR_CTRLE_CLR = 6'h04; // Clear strobe for control E
  localparam logic [5:0] ADDR_CTRLE_SET = 6'h05; // Set strobe for control E
  localparam logic [5:0] ADDR_COUNT_LO = 6'h20; // Counter, read only here
  localparam logic [5:0] ADDR_COUNT_HI = 6'h21;
  localparam logic [5:0] ADDR_PERIOD_LO = 6'h26; // Period, written directly
  localparam logic [5:0] ADDR_PERIOD_HI = 6'h27;
  localparam logic [5:0] ADDR_CMPBUF_BASE = 6'h38; // Buffer n low byte at base+2n
  localparam logic [5:0] ADDR_STATUS = 6'h3e; // Running flag and valid flags
  // ==========================================================
  // Field positions
  localparam int A_RUN_STDBY_BIT = 7;
  localparam int A_PRESC_LSB = 1;
  localparam int A_ENABLE_BIT = 0;
  localparam int D_SPLIT_BIT = 0;
  localparam int E_CMD_LSB = 2;
  localparam int E_LOCK_BIT = 1;
  localparam int E_DIR_BIT = 0;
  localparam int NUM_CH = 3;
  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] PERIOD_RST = 16'hffff;
  localparam logic [15:0] CMP_RST = 16'h0000;
  // ==========================================================
  // Waveform mode codes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_FREQ = 3'h1;
  localparam logic [2:0] MODE_SINGLE = 3'h3;
  localparam logic [2:0] MODE_DS_TOP = 3'h5;
  localparam logic [2:0] MODE_DS_BOTH = 3'h6;
  localparam logic [2:0] MODE_DS_BOTTOM = 3'h7;
  // Command codes
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_UPDATE = 2'h1;
  localparam logic [1:0] CMD_RESTART = 2'h2;
  localparam logic [1:0] CMD_HARD_RESET = 2'h3;
  // Prescaler masks: tick when all masked bits are ones (1,2,4,8,16,64,256,1024)
  localparam logic [9:0] PRESC_MASK [0:7] = '{10'h000, 10'h001, 10'h003, 10'h007,
                                              10'h00f, 10'h03f, 10'h0ff, 10'h3ff};
  // ==========================================================
  // Control B layout
  typedef struct packed {
    logic reserved;          // Bit 7, reads zero
    logic [2:0] cmp_en;      // Bits 6:4, channel 2..0
    logic auto_lock;         // Bit 3
    logic [2:0] wave_mode;   // Bits 2:0
  } tmrctl_timer_control_b_t;
endpackage

/* design/tmrctl_top.sv */
/*
  Control register logic of a 16-bit timer in normal mode: prescaler, counter
  sequencing per waveform mode, update locking, compare buffers and the
  waveform levels that go to the pads and to the logic cell link.
  Assumes a single 100 MHz clock, a register port on the same clock, and a
  standby indication from the power controller on the same clock.
*/
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps

module tmrctl_top (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic standby_in,
  output logic [2:0] wave_pin_out,
  output logic [2:0] wave_pin_oe_out,
  output logic [2:0] wave_link_out,
  output logic update_out,
  output logic overflow_out,
  output logic split_mode_out,
  output logic count_dir_out,
  output logic running_out
);
  // ==========================================================
  // Register state
  logic [7:0] ctrl_a_ff; // Standby run, prescaler, enable
  tmrctl_pkg::tmrctl_timer_control_b_t ctrl_b_ff; // Output enables, auto-lock, mode
  logic split_ff; // Split mode select
  logic lock_ff; // Update lock
  logic dir_ff; // Count direction, 1 = down
  logic [15:0] period_ff; // Period, TOP in most modes
  logic [15:0] count_ff; // Counter
  logic [9:0] presc_ff; // Prescaler counter
  logic [15:0] cmpbuf_ff [tmrctl_pkg::NUM_CH]; // Compare buffers
  logic [15:0] cmp_ff [tmrctl_pkg::NUM_CH]; // Active compare values
  logic [2:0] valid_ff; // Buffer valid flags
  logic [2:0] level_ff; // Waveform generator levels
  logic [7:0] rdata_ff; // Read data, one cycle after strobe
  logic update_ff; // Load pulse
  logic overflow_ff; // Overflow pulse
  logic running_ff; // Registered run state
  // ==========================================================
  // Decode of writes and commands
  logic wr_a, wr_b, wr_c, wr_d, wr_eclr, wr_eset, wr_e;
  logic [1:0] cmd; // Command field of a control E write
  logic cmd_update, cmd_restart, cmd_hard;
  logic enable, run, tick;
  logic [2:0] presc_sel;
  tmrctl_pkg::tmrctl_timer_control_b_t wr_b_data; // Write data seen as control B fields

  assign wr_a = reg_wr_in && (reg_addr_in == tmrctl_pkg::ADDR_CTRL_A);
  assign wr_b = reg_wr_in && (reg_addr_in == tmrctl_pkg::ADDR_CTRL_B);
  assign wr_c = reg_wr_in && (reg_addr_in == tmrctl_pkg::ADDR_CTRL_C);
  assign wr_d = reg_wr_in && (reg_addr_in == tmrctl_pkg::ADDR_CTRL_D);
  assign wr_eclr = reg_wr_in && (reg_addr_in == tmrctl_pkg::ADDR_CTRLE_CLR);
  assign wr_eset = reg_wr_in && (reg_addr_in == tmrctl_pkg::ADDR_CTRLE_SET);
  assign wr_e = wr_eclr || wr_eset;
  assign wr_b_data = tmrctl_pkg::tmrctl_timer_control_b_t'(reg_wdata_in);
  // Command acts from either half of control E; it is never stored
  assign cmd = reg_wdata_in[tmrctl_pkg::E_CMD_LSB +: 2];
  assign cmd_update = wr_e && (cmd == tmrctl_pkg::CMD_UPDATE);
  assign cmd_restart = wr_e && (cmd == tmrctl_pkg::CMD_RESTART);
  // Hard reset only while disabled, so a running output never glitches
  assign cmd_hard = wr_e && (cmd == tmrctl_pkg::CMD_HARD_RESET) && !enable;
  assign enable = ctrl_a_ff[tmrctl_pkg::A_ENABLE_BIT];
  assign presc_sel = ctrl_a_ff[tmrctl_pkg::A_PRESC_LSB +: 3];
  // Standby halts the timer unless standby run is set
  assign run = enable && (!standby_in || ctrl_a_ff[tmrctl_pkg::A_RUN_STDBY_BIT]);
  // One tick per divided period
  assign tick = run && ((presc_ff & tmrctl_pkg::PRESC_MASK[presc_sel]) ==
                        tmrctl_pkg::PRESC_MASK[presc_sel]);

  // ==========================================================
  // Counter sequencing per mode
  logic [15:0] top; // Current TOP value
  logic is_top, is_bottom;
  logic [15:0] nxt_count;
  logic upd_cond, ovf_cond, dir_flip;
  logic [2:0] match; // Counter equals compare value
  logic load_hw, load, all_valid;

  // Frequency mode uses compare 0 as TOP
  assign top = (ctrl_b_ff.wave_mode == tmrctl_pkg::MODE_FREQ) ? cmp_ff[0] : period_ff;
  assign is_top = (count_ff == top);
  assign is_bottom = (count_ff == 16'h0000);

  // Next count, update and overflow points, hardware direction changes
  always_comb begin
    nxt_count = count_ff;
    upd_cond = 1'b0;
    ovf_cond = 1'b0;
    dir_flip = 1'b0;
    if (tick) begin
      case (ctrl_b_ff.wave_mode)
        tmrctl_pkg::MODE_SINGLE: begin
          // Wraps to BOTTOM; update and overflow there
          if (is_top) begin
            nxt_count = 16'h0000;
            upd_cond = 1'b1;
            ovf_cond = 1'b1;
          end else begin
            nxt_count = count_ff + 16'h0001;
          end
        end
        tmrctl_pkg::MODE_DS_TOP, tmrctl_pkg::MODE_DS_BOTH,
        tmrctl_pkg::MODE_DS_BOTTOM: begin
          if (!dir_ff) begin
            // Rising slope, turn at TOP
            if (is_top) begin
              nxt_count = count_ff - 16'h0001;
              dir_flip = 1'b1;
              ovf_cond = (ctrl_b_ff.wave_mode != tmrctl_pkg::MODE_DS_BOTTOM);
            end else begin
              nxt_count = count_ff + 16'h0001;
            end
          end else begin
            // Falling slope, turn at BOTTOM where updates happen
            if (is_bottom) begin
              nxt_count = count_ff + 16'h0001;
              dir_flip = 1'b1;
              upd_cond = 1'b1;
              ovf_cond = (ctrl_b_ff.wave_mode != tmrctl_pkg::MODE_DS_TOP);
            end else begin
              nxt_count = count_ff - 16'h0001;
            end
          end
        end
        default: begin
          // Normal, frequency and reserved codes: single direction per bit
          if (!dir_ff) begin
            if (is_top) begin
              nxt_count = 16'h0000;
              upd_cond = 1'b1;
              ovf_cond = 1'b1;
            end else begin
              nxt_count = count_ff + 16'h0001;
            end
          end else begin
            if (is_bottom) begin
              nxt_count = top;
              upd_cond = 1'b1;
              ovf_cond = 1'b1;
            end else begin
              nxt_count = count_ff - 16'h0001;
            end
          end
        end
      endcase
    end
  end

  // Locked update conditions are swallowed; a forced update always loads
  assign load_hw = upd_cond && !lock_ff;
  assign load = load_hw || cmd_update;
  // Channels with outputs disabled do not hold the unlock back
  assign all_valid = &(valid_ff | ~ctrl_b_ff.cmp_en);

  // ==========================================================
  // Control A: standby run, prescaler, enable
  always_ff @(posedge clock_in) begin
    if (!reset_n_in || cmd_hard) begin
      ctrl_a_ff <= tmrctl_pkg::CTRL_RST;
    end else if (wr_a) begin
      // Bits 6:4 are unused and read zero
      ctrl_a_ff <= reg_wdata_in & 8'h8f;
    end
  end

  // Control B and split mode
  always_ff @(posedge clock_in) begin
    if (!reset_n_in || cmd_hard) begin
      ctrl_b_ff <= tmrctl_pkg::tmrctl_timer_control_b_t'(tmrctl_pkg::CTRL_RST);
      split_ff <= 1'b0;
    end else begin
      if (wr_b) begin
        ctrl_b_ff <= tmrctl_pkg::tmrctl_timer_control_b_t'(reg_wdata_in & 8'h7f);
      end
      if (wr_d) begin
        // Only the select is held; the 8-bit pair lives elsewhere
        split_ff <= reg_wdata_in[tmrctl_pkg::D_SPLIT_BIT];
      end
    end
  end

  // ==========================================================
  // Update lock: software set/clear wins over the auto-lock machinery
  always_ff @(posedge clock_in) begin
    if (!reset_n_in || cmd_hard) begin
      lock_ff <= 1'b0;
    end else if (wr_eset && reg_wdata_in[tmrctl_pkg::E_LOCK_BIT]) begin
      lock_ff <= 1'b1;
    end else if (wr_eclr && reg_wdata_in[tmrctl_pkg::E_LOCK_BIT]) begin
      lock_ff <= 1'b0;
    end else if (wr_b && wr_b_data.auto_lock && !ctrl_b_ff.auto_lock) begin
      lock_ff <= 1'b1; // Lock at once when auto-lock turns on
    end else if (ctrl_b_ff.auto_lock) begin
      if (load_hw) begin
        lock_ff <= 1'b1;
      end else if (lock_ff && all_valid) begin
        lock_ff <= 1'b0;
      end
    end
  end

  // Direction: software set/clear, hardware turns in dual slope
  always_ff @(posedge clock_in) begin
    if (!reset_n_in || cmd_hard || cmd_restart) begin
      dir_ff <= 1'b0;
    end else if (wr_eset && reg_wdata_in[tmrctl_pkg::E_DIR_BIT]) begin
      dir_ff <= 1'b1;
    end else if (wr_eclr && reg_wdata_in[tmrctl_pkg::E_DIR_BIT]) begin
      dir_ff <= 1'b0;
    end else if (dir_flip) begin
      dir_ff <= !dir_ff;
    end
  end

  // ==========================================================
  // Prescaler: cleared while stopped so the first tick is a full period
  always_ff @(posedge clock_in) begin
    if (!reset_n_in || cmd_hard || cmd_restart || !run) begin
      presc_ff <= 10'h000;
    end else begin
      presc_ff <= presc_ff + 10'h001;
    end
  end

  // Counter holds unless ticked
  always_ff @(posedge clock_in) begin
    if (!reset_n_in || cmd_hard || cmd_restart) begin
      count_ff <= 16'h0000;
    end else if (tick) begin
      count_ff <= nxt_count;
    end
  end

  // Period, written directly byte by byte
  always_ff @(posedge clock_in) begin
    if (!reset_n_in || cmd_hard) begin
      period_ff <= tmrctl_pkg::PERIOD_RST;
    end else if (reg_wr_in && (reg_addr_in == tmrctl_pkg::ADDR_PERIOD_LO)) begin
      period_ff[7:0] <= reg_wdata_in;
    end else if (reg_wr_in && (reg_addr_in == tmrctl_pkg::ADDR_PERIOD_HI)) begin
      period_ff[15:8] <= reg_wdata_in;
    end
  end

  // ==========================================================
  // Compare buffers, valid flags and active compare values
  always_ff @(posedge clock_in) begin
    if (!reset_n_in || cmd_hard) begin
      for (int n = 0; n < tmrctl_pkg::NUM_CH; n++) begin
        cmpbuf_ff[n] <= tmrctl_pkg::CMP_RST;
        cmp_ff[n] <= tmrctl_pkg::CMP_RST;
        valid_ff[n] <= 1'b0;
      end
    end else begin
      for (int n = 0; n < tmrctl_pkg::NUM_CH; n++) begin
        if (reg_wr_in && (reg_addr_in == 6'(tmrctl_pkg::ADDR_CMPBUF_BASE + 2 * n))) begin
          cmpbuf_ff[n][7:0] <= reg_wdata_in;
        end
        // High byte completes the value; its write sets valid and beats a clear
        if (reg_wr_in && (reg_addr_in == 6'(tmrctl_pkg::ADDR_CMPBUF_BASE + 2 * n + 1))) begin
          cmpbuf_ff[n][15:8] <= reg_wdata_in;
          valid_ff[n] <= 1'b1;
        end else if (load) begin
          valid_ff[n] <= 1'b0;
        end
        if (load) begin
          cmp_ff[n] <= cmpbuf_ff[n];
        end
      end
    end
  end

  // ==========================================================
  // Waveform levels
  always_comb begin
    for (int n = 0; n < tmrctl_pkg::NUM_CH; n++) begin
      match[n] = (count_ff == cmp_ff[n]);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in || cmd_hard) begin
      level_ff <= 3'h0;
    end else if (!enable) begin
      // Direct override only while disabled
      if (wr_c) begin
        level_ff <= reg_wdata_in[2:0];
      end
    end else if (tick) begin
      case (ctrl_b_ff.wave_mode)
        tmrctl_pkg::MODE_FREQ: begin
          // Toggle once per period
          if (upd_cond) begin
            level_ff[0] <= !level_ff[0];
          end
        end
        tmrctl_pkg::MODE_SINGLE: begin
          for (int n = 0; n < tmrctl_pkg::NUM_CH; n++) begin
            if (upd_cond) begin
              level_ff[n] <= 1'b1;
            end else if (match[n]) begin
              level_ff[n] <= 1'b0;
            end
          end
        end
        tmrctl_pkg::MODE_DS_TOP, tmrctl_pkg::MODE_DS_BOTH,
        tmrctl_pkg::MODE_DS_BOTTOM: begin
          // Clear on the way up, set on the way down
          for (int n = 0; n < tmrctl_pkg::NUM_CH; n++) begin
            if (match[n]) begin
              level_ff[n] <= dir_ff;
            end
          end
        end
        default: level_ff <= level_ff;
      endcase
    end
  end

  // ==========================================================
  // Event pulses and run state
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      update_ff <= 1'b0;
      overflow_ff <= 1'b0;
      running_ff <= 1'b0;
    end else begin
      update_ff <= load;
      overflow_ff <= ovf_cond;
      running_ff <= run;
    end
  end

  // ==========================================================
  // Read port: data stand in the cycle after the strobe only
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        tmrctl_pkg::ADDR_CTRL_A: rdata_ff <= ctrl_a_ff;
        tmrctl_pkg::ADDR_CTRL_B: rdata_ff <= ctrl_b_ff;
        tmrctl_pkg::ADDR_CTRL_C: rdata_ff <= {5'h00, level_ff};
        tmrctl_pkg::ADDR_CTRL_D: rdata_ff <= {7'h00, split_ff};
        // Command field always reads zero
        tmrctl_pkg::ADDR_CTRLE_CLR,
        tmrctl_pkg::ADDR_CTRLE_SET: rdata_ff <= {6'h00, lock_ff, dir_ff};
        tmrctl_pkg::ADDR_COUNT_LO: rdata_ff <= count_ff[7:0];
        tmrctl_pkg::ADDR_COUNT_HI: rdata_ff <= count_ff[15:8];
        tmrctl_pkg::ADDR_PERIOD_LO: rdata_ff <= period_ff[7:0];
        tmrctl_pkg::ADDR_PERIOD_HI: rdata_ff <= period_ff[15:8];
        tmrctl_pkg::ADDR_STATUS: rdata_ff <= {4'h0, running_ff, valid_ff};
        default: rdata_ff <= 8'h00; // Unmapped reads zero
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // ==========================================================
  // Outputs, all straight from flip-flops
  assign reg_rdata_out = rdata_ff;
  assign wave_pin_out = level_ff;
  // Pad takes the level only where enabled; port must be set as output
  assign wave_pin_oe_out = ctrl_b_ff.cmp_en;
  // Link side bypasses the enables
  assign wave_link_out = level_ff;
  assign update_out = update_ff;
  assign overflow_out = overflow_ff;
  assign split_mode_out = split_ff;
  assign count_dir_out = dir_ff;
  assign running_out = running_ff;
endmodule // tmrctl_top

/* verification/tmrctl_properties.sv */
/*
  Port-level assertions for the timer control block.
  Assumes binding to tmrctl_top, one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
module tmrctl_properties (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic standby_in,
  input wire logic [2:0] wave_pin_out,
  input wire logic [2:0] wave_pin_oe_out,
  input wire logic [2:0] wave_link_out,
  input wire logic update_out,
  input wire logic overflow_out,
  input wire logic split_mode_out,
  input wire logic count_dir_out,
  input wire logic running_out
);
  // ==========================================================
  // Clocking
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  // Forced update command on the set register
  sequence s_upd_cmd;
    reg_wr_in && reg_addr_in == tmrctl_pkg::ADDR_CTRLE_SET && reg_wdata_in[3:2] == 2'h1;
  endsequence
  // Bus quiet and counter halted
  sequence s_stop_quiet;
    !reg_wr_in && !running_out;
  endsequence
  // ==========================================================
  // Properties
  property p_cmp_en;
    logic [2:0] v;
    (reg_wr_in && reg_addr_in == tmrctl_pkg::ADDR_CTRL_B, v = reg_wdata_in[6:4])
      ##1 !reg_wr_in |-> ##1 wave_pin_oe_out == v;
  endproperty
  property p_split;
    logic v;
    (reg_wr_in && reg_addr_in == tmrctl_pkg::ADDR_CTRL_D, v = reg_wdata_in[0])
      ##1 !reg_wr_in |-> ##1 split_mode_out == v;
  endproperty
  // Standby halts unless the standby bit was written with enable
  property p_run;
    logic [7:0] v;
    (reg_wr_in && reg_addr_in == tmrctl_pkg::ADDR_CTRL_A, v = reg_wdata_in) ##1 !reg_wr_in
      |-> ##1 running_out == (v[0] && (v[7] || !$past(standby_in)));
  endproperty
  // Halted counter cannot flip direction by itself
  property p_dir;
    (reg_wr_in && reg_addr_in == tmrctl_pkg::ADDR_CTRLE_SET && reg_wdata_in[0]
      && !reg_wdata_in[3] && !running_out) ##1 s_stop_quiet |-> ##1 (count_dir_out || running_out);
  endproperty
  property p_cmd_rd;
    (reg_rd_in && (reg_addr_in == tmrctl_pkg::ADDR_CTRLE_CLR
      || reg_addr_in == tmrctl_pkg::ADDR_CTRLE_SET)) |=> reg_rdata_out[7:2] == 6'h00;
  endproperty
  property p_force;
    s_upd_cmd |-> ##[1:2] update_out;
  endproperty
  property p_ovf;
    overflow_out |-> (running_out || $past(running_out) || $past(running_out, 2));
  endproperty
  property p_upd;
    update_out |-> (running_out || $past(running_out) || $past(reg_wr_in) || $past(reg_wr_in, 2));
  endproperty
  // ==========================================================
  // Assertions
  a_cmp_en: assert property (p_cmp_en) else $error("output enables differ from control B");
  a_split: assert property (p_split) else $error("split output differs from control D");
  a_run: assert property (p_run) else $error("running differs from enable and standby");
  a_dir: assert property (p_dir) else $error("direction not set by set register");
  a_cmd_rd: assert property (p_cmd_rd) else $error("command field read non zero");
  a_force: assert property (p_force) else $error("forced update gave no load");
  a_ovf: assert property (p_ovf) else $error("overflow while halted");
  a_upd: assert property (p_upd) else $error("load without cause");
endmodule // tmrctl_properties

/* verification/tmrctl_tb.sv */
/*
  Self-checking bench for the timer control block over its register port.
  Assumes the bench alone drives every input of tmrctl_top.
*/
`timescale 1ns/1ps
module testbench;
  logic clock_in, reset_n_in, reg_wr_in, reg_rd_in, standby_in;
  logic [5:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, rd_lo, rd_hi;
  logic [2:0] wave_pin_out, wave_pin_oe_out, wave_link_out, last_link;
  logic update_out, overflow_out, split_mode_out, count_dir_out, running_out;
  int err_total, tests_run, cyc, ovf_n, upd_n, tog_n;
  int dv [0:7] = '{1, 2, 4, 8, 16, 64, 256, 1024}; // Prescaler ratios
  logic [2:0] md [0:3] = '{3'h0, 3'h1, 3'h3, 3'h5}; // Modes exercised
  int ex [0:3] = '{20, 20, 20, 11}; // Events in 200 cycles, TOP 9
  tmrctl_top dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .standby_in(standby_in), .wave_pin_out(wave_pin_out),
    .wave_pin_oe_out(wave_pin_oe_out), .wave_link_out(wave_link_out), .update_out(update_out),
    .overflow_out(overflow_out), .split_mode_out(split_mode_out),
    .count_dir_out(count_dir_out), .running_out(running_out));
  // ==========================================================
  // Clock, event counters, timeout (ceiling well above about 17.6k cycles)
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cyc++;
    if (overflow_out === 1'b1) ovf_n++;
    if (update_out === 1'b1) upd_n++;
    if (wave_link_out[0] !== last_link[0]) tog_n++;
    last_link = wave_link_out;
    if (cyc == 30000) begin
      err_total++;
      summarize();
    end
  end
  // ==========================================================
  // Bus tasks: one gap cycle after each strobe keeps drivers single-assigned
  task automatic w(input logic [5:0] a, input logic [7:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1;
    d = reg_rdata_out; // Data stands only this cycle
    @(posedge clock_in);
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Counts whose phase is not fixed get a margin of two
  task automatic near(input string n, input int e, input logic [15:0] g);
    tests_run++;
    if ((g + 2 >= e && g <= e + 2) !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk($sformatf("register %h", a), {8'h00, e}, {8'h00, d});
  endtask
  task automatic run(input logic [7:0] a, input int n);
    w(tmrctl_pkg::ADDR_CTRL_A, a);
    repeat (n) @(posedge clock_in);
    w(tmrctl_pkg::ADDR_CTRL_A, 8'h00);
  endtask
  task automatic summarize;
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {reset_n_in, reg_wr_in, reg_rd_in, standby_in, reg_addr_in, reg_wdata_in} = '0;
    last_link = 3'h0;
    repeat (20) @(posedge clock_in);
    reset_n_in <= 1'b1;
    @(posedge clock_in);
    for (int a = 0; a < 6; a++) rc(a[5:0], 8'h00); // Control reset values zero
    rc(6'h27, 8'hff); // Period reset
    w(6'h10, 8'hff);
    rc(6'h10, 8'h00); // Unmapped place
    w(tmrctl_pkg::ADDR_CTRL_A, 8'hfe);
    rc(tmrctl_pkg::ADDR_CTRL_A, 8'h8e); // unused bits read zero
    w(tmrctl_pkg::ADDR_CTRLE_SET, 8'h03);
    rc(tmrctl_pkg::ADDR_CTRLE_CLR, 8'h03);
    chk("direction", 16'h1, {15'h0, count_dir_out});
    w(tmrctl_pkg::ADDR_CTRLE_CLR, 8'h03);
    rc(tmrctl_pkg::ADDR_CTRLE_SET, 8'h00);
    // Override, enables, split, then hard reset while disabled
    w(tmrctl_pkg::ADDR_CTRL_C, 8'h05);
    chk("link levels", 16'h5, {13'h0, wave_link_out});
    chk("pad levels", 16'h5, {13'h0, wave_pin_out});
    w(tmrctl_pkg::ADDR_CTRL_B, 8'h57);
    chk("pad enables", 16'h5, {13'h0, wave_pin_oe_out});
    w(tmrctl_pkg::ADDR_CTRL_D, 8'h01);
    chk("split", 16'h1, {15'h0, split_mode_out});
    w(tmrctl_pkg::ADDR_CTRLE_SET, 8'h0c);
    rc(tmrctl_pkg::ADDR_CTRL_B, 8'h00);
    rc(tmrctl_pkg::ADDR_CTRL_C, 8'h00);
    rc(tmrctl_pkg::ADDR_CTRL_D, 8'h00);
    w(tmrctl_pkg::ADDR_CTRL_B, 8'h10);
    w(tmrctl_pkg::ADDR_CTRL_A, 8'h01);
    w(tmrctl_pkg::ADDR_CTRLE_SET, 8'h0c);
    rc(tmrctl_pkg::ADDR_CTRL_B, 8'h10);
    // Standby halts unless standby run is set
    standby_in <= 1'b1;
    @(posedge clock_in);
    rc(tmrctl_pkg::ADDR_STATUS, 8'h00);
    w(tmrctl_pkg::ADDR_CTRL_A, 8'h81);
    rc(tmrctl_pkg::ADDR_STATUS, 8'h08);
    w(tmrctl_pkg::ADDR_CTRL_A, 8'h00);
    standby_in <= 1'b0;
    // Every prescaler code over 2048 cycles
    for (int c = 0; c < 8; c++) begin
      w(tmrctl_pkg::ADDR_CTRLE_SET, 8'h08);
      run({4'h0, c[2:0], 1'b1}, 2048);
      rd(tmrctl_pkg::ADDR_COUNT_LO, rd_lo);
      rd(tmrctl_pkg::ADDR_COUNT_HI, rd_hi);
      near("count", 2048 / dv[c], {rd_hi, rd_lo});
    end
    // Period and compare 0 of 9, loaded by force
    w(6'h26, 8'h09);
    w(6'h27, 8'h00);
    w(6'h38, 8'h09);
    w(6'h39, 8'h00);
    rc(tmrctl_pkg::ADDR_STATUS, 8'h01);
    w(tmrctl_pkg::ADDR_CTRLE_SET, 8'h04);
    rc(tmrctl_pkg::ADDR_STATUS, 8'h00);
    for (int i = 0; i < 4; i++) begin
      w(tmrctl_pkg::ADDR_CTRL_B, {5'h02, md[i]});
      w(tmrctl_pkg::ADDR_CTRLE_SET, 8'h08);
      ovf_n = 0;
      upd_n = 0;
      tog_n = 0;
      run(8'h01, 200);
      near("overflows", ex[i], ovf_n[15:0]);
      near("updates", ex[i], upd_n[15:0]);
      if (i == 0) chk("normal toggles", 16'h0, tog_n[15:0]);
      if (i == 1) near("frequency toggles", 20, tog_n[15:0]);
    end
    // Manual lock blocks loads, release lets them through
    w(tmrctl_pkg::ADDR_CTRL_B, 8'h10);
    w(tmrctl_pkg::ADDR_CTRLE_SET, 8'h02);
    w(6'h39, 8'h00);
    upd_n = 0;
    run(8'h01, 50);
    chk("locked loads", 16'h0, upd_n[15:0]);
    rc(tmrctl_pkg::ADDR_STATUS, 8'h01);
    rc(tmrctl_pkg::ADDR_CTRLE_CLR, 8'h02);
    w(tmrctl_pkg::ADDR_CTRLE_CLR, 8'h02);
    upd_n = 0;
    run(8'h01, 50);
    near("free loads", 5, upd_n[15:0]);
    rc(tmrctl_pkg::ADDR_STATUS, 8'h00);
    // Auto-lock with channels 0 and 1 enabled
    w(tmrctl_pkg::ADDR_CTRL_B, 8'h38);
    rc(tmrctl_pkg::ADDR_CTRLE_CLR, 8'h02);
    run(8'h01, 30);
    rc(tmrctl_pkg::ADDR_CTRLE_CLR, 8'h02);
    w(6'h39, 8'h00);
    rc(tmrctl_pkg::ADDR_CTRLE_CLR, 8'h02);
    w(6'h3b, 8'h00);
    rc(tmrctl_pkg::ADDR_CTRLE_CLR, 8'h00);
    run(8'h01, 30);
    rc(tmrctl_pkg::ADDR_STATUS, 8'h00);
    rc(tmrctl_pkg::ADDR_CTRLE_CLR, 8'h02);
    summarize();
  end
endmodule // testbench

bind tmrctl_top tmrctl_properties u_props (.clock_in(clock_in), .reset_n_in(reset_n_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .standby_in(standby_in),
  .wave_pin_out(wave_pin_out), .wave_pin_oe_out(wave_pin_oe_out), .wave_link_out(wave_link_out),
  .update_out(update_out), .overflow_out(overflow_out), .split_mode_out(split_mode_out),
  .count_dir_out(count_dir_out), .running_out(running_out));
